// ===== verilog/cid_pkg.sv
package cid_pkg;

    // format index: 1..19, zero marks an undefined halfword
    typedef enum logic [4:0] {
        CID_FMT_NONE = 5'h00,
        CID_FMT_SHIFT = 5'h01,
        CID_FMT_ADDSUB = 5'h02,
        CID_FMT_IMM8 = 5'h03,
        CID_FMT_ALU = 5'h04,
        CID_FMT_HIREG = 5'h05,
        CID_FMT_PCLOAD = 5'h06,
        CID_FMT_LS_REG = 5'h07,
        CID_FMT_LS_SIGN = 5'h08,
        CID_FMT_LS_IMM = 5'h09,
        CID_FMT_LS_HALF = 5'h0A,
        CID_FMT_LS_SP = 5'h0B,
        CID_FMT_LOAD_ADDR = 5'h0C,
        CID_FMT_SP_ADJ = 5'h0D,
        CID_FMT_PUSH_POP = 5'h0E,
        CID_FMT_MULTI = 5'h0F,
        CID_FMT_COND_BR = 5'h10,
        CID_FMT_TRAP = 5'h11,
        CID_FMT_UNCOND_BR = 5'h12,
        CID_FMT_LONG_BR = 5'h13
    } cid_fmt_e;

    // field positions inside the halfword
    localparam int unsigned CID_RD_LO = 0;       // low register destination
    localparam int unsigned CID_RS_LO = 3;       // low register source / base
    localparam int unsigned CID_RN_LO = 6;       // offset register / 3-bit immediate
    localparam int unsigned CID_OFF5_LO = 6;     // five_bit_offset field
    localparam int unsigned CID_RD8_LO = 8;      // register field of 8-bit formats
    localparam int unsigned CID_HI_RS_BIT = 6;   // high-bank flag of source
    localparam int unsigned CID_HI_RD_BIT = 7;   // high-bank flag of destination
    localparam int unsigned CID_OP2_LO = 11;     // 2-bit op of formats 1 and 3
    localparam int unsigned CID_LOAD_BIT = 11;   // load / not store
    localparam int unsigned CID_BYTE9_BIT = 12;  // byte select of format 9
    localparam int unsigned CID_BYTE7_BIT = 10;  // byte select of format 7
    localparam int unsigned CID_IMM2_BIT = 10;   // immediate select of format 2
    localparam int unsigned CID_SUB2_BIT = 9;    // subtract select of format 2
    localparam int unsigned CID_SP_SEL_BIT = 11; // stack base select of format 12
    localparam int unsigned CID_SIGN13_BIT = 7;  // offset sign of format 13
    localparam int unsigned CID_EXTRA_BIT = 8;   // extra register of format 14
    localparam int unsigned CID_COND_LO = 8;     // condition field of format 16
    localparam int unsigned CID_HALF_SEL_BIT = 11; // H bit of format 19
    localparam logic [1:0] CID_OP2_RESERVED = 2'h3; // format 1 op value owned by format 2
    localparam logic [1:0] CID_HI_MOVE_OP = 2'h2;   // format 5 register move
    localparam logic [1:0] CID_HI_ADD_OP = 2'h0;    // format 5 add
    localparam logic [1:0] CID_HI_EXCH_OP = 2'h3;   // format 5 branch exchange
    localparam logic [3:0] CID_COND_TRAP = 4'hF;    // condition code that means trap
    localparam int unsigned CID_LONG_HI_SHIFT = 12; // upper half of long offset

    // expanded full-width equivalent of one halfword
    typedef struct packed {
        cid_fmt_e fmt;             // encoding format
        logic undef;               // halfword matches no format
        logic set_flags;           // wide op updates condition flags
        logic [3:0] op;            // operation code within the format
        logic [3:0] rd;            // destination, bit 3 set for high bank
        logic [3:0] rs;            // source or base, bit 3 set for high bank
        logic [2:0] rn;            // offset register
        logic reg_operand;         // rn is a register, not an immediate
        logic load;                // load rather than store
        logic byte_sel;            // byte rather than word access
        logic hpart;               // second half of a long branch offset
        logic branch_exchange_op;  // branch with state exchange
        logic branch_link_op;      // long branch with link
        logic software_trap_op;    // software trap
        logic load_multiple_op;    // block load
        logic store_multiple_op;   // block store
        logic [31:0] imm;          // scaled and extended immediate
    } cid_exp_s;

endpackage : cid_pkg

// ===== verilog/cid_fmt_class.sv
`timescale 1ns/100ps
// picks the encoding format from the leading opcode bits alone
module cid_fmt_class import cid_pkg::*; (
    input wire logic [15:0] i_half,
    output cid_fmt_e o_fmt
);

    // no priority order: the patterns do not overlap and are listed by rising opcode value
    always_comb begin
        o_fmt = CID_FMT_NONE;
        unique casez (i_half[15:8])
            8'b000?????: o_fmt = (i_half[12:11] == CID_OP2_RESERVED) ? CID_FMT_ADDSUB : CID_FMT_SHIFT;
            8'b001?????: o_fmt = CID_FMT_IMM8;
            8'b010000??: o_fmt = CID_FMT_ALU;
            8'b010001??: o_fmt = CID_FMT_HIREG;
            8'b01001???: o_fmt = CID_FMT_PCLOAD;
            8'b0101????: o_fmt = i_half[9] ? CID_FMT_LS_SIGN : CID_FMT_LS_REG;
            8'b011?????: o_fmt = CID_FMT_LS_IMM;
            8'b1000????: o_fmt = CID_FMT_LS_HALF;
            8'b1001????: o_fmt = CID_FMT_LS_SP;
            8'b1010????: o_fmt = CID_FMT_LOAD_ADDR;
            8'b1011????: begin
                // only the all-zero tail and the push/pop pattern are defined here
                if (i_half[11:8] == 4'h0) begin
                    o_fmt = CID_FMT_SP_ADJ;
                end else if (i_half[10:9] == 2'h2) begin
                    o_fmt = CID_FMT_PUSH_POP;
                end else begin
                    o_fmt = CID_FMT_NONE;
                end
            end
            8'b1100????: o_fmt = CID_FMT_MULTI;
            8'b1101????: o_fmt = (i_half[11:8] == CID_COND_TRAP) ? CID_FMT_TRAP : CID_FMT_COND_BR;
            8'b11100???: o_fmt = CID_FMT_UNCOND_BR;
            8'b1111????: o_fmt = CID_FMT_LONG_BR;
            default: o_fmt = CID_FMT_NONE;
        endcase
    end

endmodule : cid_fmt_class

// ===== verilog/cid_decoder.sv
`timescale 1ns/100ps
// expands one compressed halfword per valid strobe into a wide operation
module cid_decoder import cid_pkg::*; (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_valid,       // halfword on i_half is offered
    input wire logic [15:0] i_half, // compressed instruction
    output logic o_valid,           // expanded operation is presented
    output cid_exp_s o_exp          // expanded operation
);

    // sign-extend a field of any width up to 32 bits
    function automatic logic [31:0] sext(input logic [31:0] val, input int unsigned width);
        logic [31:0] mask;
        mask = 32'hFFFFFFFF << width;
        sext = val[width - 1] ? (val | mask) : (val & ~mask);
    endfunction : sext

    // zero-extend a field then scale it by a power of two
    function automatic logic [31:0] zscale(input logic [10:0] val, input int unsigned shift);
        zscale = {21'h000000, val} << shift;
    endfunction : zscale

    // reset release path
    logic rst_meta_ff;  // first stage, read only by the second
    logic rst_sync_ff;  // synchronised active-high-to-run reset
    logic valid_ff;     // output valid register
    logic nxt_valid;
    cid_exp_s exp_ff;   // output operation register
    cid_exp_s nxt_exp;
    cid_fmt_e fmt;      // format chosen before any field is read

    // two-stage reset synchroniser; assertion is immediate, release waits two edges
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // format classifier, kept apart so the field logic can only key on its result
    cid_fmt_class u_class (
        .i_half(i_half),
        .o_fmt(fmt)
    );

    // next valid: exactly one expansion per accepted halfword
    always_comb begin
        nxt_valid = i_valid;
    end

    // field extraction, one branch per format
    always_comb begin
        nxt_exp = '0;
        nxt_exp.fmt = fmt;
        nxt_exp.rd = {1'b0, i_half[CID_RD_LO +: 3]};
        nxt_exp.rs = {1'b0, i_half[CID_RS_LO +: 3]};
        // the whole halfword is one instruction; no pairing with neighbours
        if (!i_valid) begin
            // idle cycles hold a cleared operation so stale fields never leak
            nxt_exp = '0;
        end else begin
            unique case (fmt)
                CID_FMT_SHIFT: begin
                    // shifted move; shift amount is the five_bit_offset field
                    nxt_exp.op = {2'h0, i_half[CID_OP2_LO +: 2]};
                    nxt_exp.imm = zscale({6'h00, i_half[CID_OFF5_LO +: 5]}, 0);
                    nxt_exp.set_flags = 1'b1;
                end
                CID_FMT_ADDSUB: begin
                    // add or subtract, register or 3-bit immediate
                    nxt_exp.op = {3'h0, i_half[CID_SUB2_BIT]};
                    nxt_exp.rn = i_half[CID_RN_LO +: 3];
                    nxt_exp.reg_operand = !i_half[CID_IMM2_BIT];
                    nxt_exp.imm = zscale({8'h00, i_half[CID_RN_LO +: 3]}, 0);
                    nxt_exp.set_flags = 1'b1;
                end
                CID_FMT_IMM8: begin
                    // move, compare, add, subtract on an 8-bit immediate
                    nxt_exp.op = {2'h0, i_half[CID_OP2_LO +: 2]};
                    nxt_exp.rd = {1'b0, i_half[CID_RD8_LO +: 3]};
                    nxt_exp.imm = zscale({3'h0, i_half[7:0]}, 0);
                    nxt_exp.set_flags = 1'b1;
                end
                CID_FMT_ALU: begin
                    // register-pair arithmetic and logic, all of them set flags
                    nxt_exp.op = i_half[9:6];
                    nxt_exp.set_flags = 1'b1;
                end
                CID_FMT_HIREG: begin
                    // high-bank add, compare, move or branch exchange
                    nxt_exp.op = {2'h0, i_half[9:8]};
                    nxt_exp.rd = {i_half[CID_HI_RD_BIT], i_half[CID_RD_LO +: 3]};
                    nxt_exp.rs = {i_half[CID_HI_RS_BIT], i_half[CID_RS_LO +: 3]};
                    nxt_exp.reg_operand = 1'b1;
                    nxt_exp.branch_exchange_op = (i_half[9:8] == CID_HI_EXCH_OP);
                    // add and move here leave flags alone; only compare updates them
                    nxt_exp.set_flags = (i_half[9:8] != CID_HI_ADD_OP) &&
                                        (i_half[9:8] != CID_HI_MOVE_OP) &&
                                        (i_half[9:8] != CID_HI_EXCH_OP);
                end
                CID_FMT_PCLOAD: begin
                    // word load relative to the program counter
                    nxt_exp.rd = {1'b0, i_half[CID_RD8_LO +: 3]};
                    nxt_exp.load = 1'b1;
                    nxt_exp.imm = zscale({3'h0, i_half[7:0]}, 2);
                end
                CID_FMT_LS_REG: begin
                    // load or store, base plus register offset
                    nxt_exp.load = i_half[CID_LOAD_BIT];
                    nxt_exp.byte_sel = i_half[CID_BYTE7_BIT];
                    nxt_exp.rn = i_half[CID_RN_LO +: 3];
                    nxt_exp.reg_operand = 1'b1;
                end
                CID_FMT_LS_SIGN: begin
                    // sign-extended byte/halfword; the two select bits form the op
                    nxt_exp.op = {2'h0, i_half[11:10]};
                    nxt_exp.load = (i_half[11:10] != 2'h0);
                    nxt_exp.rn = i_half[CID_RN_LO +: 3];
                    nxt_exp.reg_operand = 1'b1;
                end
                CID_FMT_LS_IMM: begin
                    // byte offsets are unscaled, word offsets count words
                    nxt_exp.byte_sel = i_half[CID_BYTE9_BIT];
                    nxt_exp.load = i_half[CID_LOAD_BIT];
                    nxt_exp.imm = zscale({6'h00, i_half[CID_OFF5_LO +: 5]},
                                         i_half[CID_BYTE9_BIT] ? 0 : 2);
                end
                CID_FMT_LS_HALF: begin
                    // halfword access, offset counts halfwords
                    nxt_exp.load = i_half[CID_LOAD_BIT];
                    nxt_exp.imm = zscale({6'h00, i_half[CID_OFF5_LO +: 5]}, 1);
                end
                CID_FMT_LS_SP: begin
                    // word access relative to the stack pointer
                    nxt_exp.load = i_half[CID_LOAD_BIT];
                    nxt_exp.rd = {1'b0, i_half[CID_RD8_LO +: 3]};
                    nxt_exp.imm = zscale({3'h0, i_half[7:0]}, 2);
                end
                CID_FMT_LOAD_ADDR: begin
                    // address from pc or sp plus word offset; flags untouched
                    nxt_exp.op = {3'h0, i_half[CID_SP_SEL_BIT]};
                    nxt_exp.rd = {1'b0, i_half[CID_RD8_LO +: 3]};
                    nxt_exp.imm = zscale({3'h0, i_half[7:0]}, 2);
                    nxt_exp.set_flags = 1'b0;
                end
                CID_FMT_SP_ADJ: begin
                    // stack_word_offset counts words; sign bit picks add or subtract
                    nxt_exp.op = {3'h0, i_half[CID_SIGN13_BIT]};
                    nxt_exp.imm = i_half[CID_SIGN13_BIT] ?
                                  (32'h00000000 - zscale({4'h0, i_half[6:0]}, 2)) :
                                  zscale({4'h0, i_half[6:0]}, 2);
                    nxt_exp.set_flags = 1'b0;
                end
                CID_FMT_PUSH_POP: begin
                    // register list in imm[7:0], link/pc extra register in imm[8]
                    nxt_exp.load = i_half[CID_LOAD_BIT];
                    nxt_exp.imm = zscale({2'h0, i_half[CID_EXTRA_BIT:0]}, 0);
                end
                CID_FMT_MULTI: begin
                    // block transfer with base write-back
                    nxt_exp.load = i_half[CID_LOAD_BIT];
                    nxt_exp.rs = {1'b0, i_half[CID_RD8_LO +: 3]};
                    nxt_exp.load_multiple_op = i_half[CID_LOAD_BIT];
                    nxt_exp.store_multiple_op = !i_half[CID_LOAD_BIT];
                    nxt_exp.imm = zscale({3'h0, i_half[7:0]}, 0);
                end
                CID_FMT_COND_BR: begin
                    // condition in op, signed halfword offset
                    nxt_exp.op = i_half[CID_COND_LO +: 4];
                    nxt_exp.imm = sext({23'h000000, i_half[7:0], 1'b0}, 9);
                end
                CID_FMT_TRAP: begin
                    // trap number passed through unchanged
                    nxt_exp.software_trap_op = 1'b1;
                    nxt_exp.imm = zscale({3'h0, i_half[7:0]}, 0);
                end
                CID_FMT_UNCOND_BR: begin
                    // signed 11-bit halfword offset
                    nxt_exp.imm = sext({20'h00000, i_half[10:0], 1'b0}, 12);
                end
                CID_FMT_LONG_BR: begin
                    // first half carries the signed upper offset, second the lower
                    nxt_exp.branch_link_op = 1'b1;
                    nxt_exp.hpart = i_half[CID_HALF_SEL_BIT];
                    nxt_exp.imm = i_half[CID_HALF_SEL_BIT] ?
                                  zscale(i_half[10:0], 1) :
                                  sext({9'h000, i_half[10:0], 12'h000}, 11 + CID_LONG_HI_SHIFT);
                end
                default: begin
                    // unknown pattern still yields one operation, marked undefined
                    nxt_exp.undef = 1'b1;
                end
            endcase
        end
    end

    // output registers; the expansion is what the execute stage acts on
    always_ff @(posedge i_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            valid_ff <= 1'b0;
            exp_ff <= '0;
        end else begin
            valid_ff <= nxt_valid;
            exp_ff <= nxt_exp;
        end
    end

    assign o_valid = valid_ff;
    assign o_exp = exp_ff;

endmodule : cid_decoder

// ===== verif/cid_decoder_sva.sv
`timescale 1ns/100ps
// watches the decoder ports; a small edge counter skips the reset synchroniser window
module cid_decoder_sva import cid_pkg::*; (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_valid,
    input wire logic [15:0] i_half,
    input wire logic o_valid,
    input wire cid_exp_s o_exp
);
    logic [1:0] up_ff; // edges since release, saturating
    logic [1:0] nxt_up;
    logic [15:0] half_ff; // halfword seen at the previous edge
    logic [15:0] nxt_half;
    logic ok; // decoder has left its internal reset
    // next helper values
    always_comb begin
        nxt_up = (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
        nxt_half = i_half;
    end
    // async clear keeps the helpers in step with the design after any reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            up_ff <= 2'h0;
            half_ff <= 16'h0000;
        end else begin
            up_ff <= nxt_up;
            half_ff <= nxt_half;
        end
    end
    assign ok = (up_ff == 2'h3);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // a halfword offered, or none offered, once the decoder is live
    sequence s_take;
        ok && i_valid;
    endsequence
    sequence s_idle;
        ok && !i_valid;
    endsequence
    one_result_a: assert property (s_take |=> o_valid)
        else $error("no result for an offered halfword");
    no_spurious_a: assert property (s_idle |=> !o_valid && o_exp == '0)
        else $error("result without an offered halfword");
    sp_adjust_a: assert property (s_take ##0 i_half[15:8] == 8'hB0 |=> o_exp.fmt == CID_FMT_SP_ADJ
        && !o_exp.set_flags && o_exp.imm == (half_ff[7] ? 32'h0 - {23'h0, half_ff[6:0], 2'h0}
        : {23'h0, half_ff[6:0], 2'h0})) else $error("stack adjust expanded wrongly");
    ls_imm_a: assert property (s_take ##0 i_half[15:13] == 3'h3 |=> o_exp.fmt == CID_FMT_LS_IMM
        && o_exp.load == half_ff[11] && o_exp.byte_sel == half_ff[12] && o_exp.rs == {1'h0, half_ff[5:3]}
        && o_exp.rd == {1'h0, half_ff[2:0]}) else $error("immediate load/store fields wrong");
    ls_offset_a: assert property (s_take ##0 i_half[15:13] == 3'h3 |=> o_exp.imm == (half_ff[12]
        ? {27'h0, half_ff[10:6]} : {25'h0, half_ff[10:6], 2'h0})) else $error("load/store offset wrong");
    long_branch_a: assert property (s_take ##0 i_half[15:12] == 4'hF |=> o_exp.fmt == CID_FMT_LONG_BR
        && o_exp.branch_link_op && o_exp.hpart == half_ff[11] && o_exp.imm == (half_ff[11]
        ? {20'h0, half_ff[10:0], 1'h0} : {{9{half_ff[10]}}, half_ff[10:0], 12'h0}))
        else $error("long branch half wrong");
    load_addr_a: assert property (s_take ##0 i_half[15:12] == 4'hA |=> o_exp.fmt == CID_FMT_LOAD_ADDR
        && !o_exp.set_flags) else $error("load address touched flags");
    hi_flags_a: assert property (s_take ##0 i_half[15:10] == 6'h11 |=> o_exp.fmt == CID_FMT_HIREG
        && o_exp.set_flags == (half_ff[9:8] == 2'h1)) else $error("high register flag choice wrong");
    lo_flags_a: assert property (s_take ##0 (i_half[15:14] == 2'h0 || i_half[15:10] == 6'h10)
        |=> o_exp.set_flags && !o_exp.undef) else $error("low register op lost its flags");
endmodule : cid_decoder_sva

bind cid_decoder cid_decoder_sva i_sva (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid), .i_half(i_half),
    .o_valid(o_valid), .o_exp(o_exp));

// ===== verif/cid_exec_sink.sv
`timescale 1ns/100ps
// stands in for the execute stage: it has no stall, so it simply consumes every presented operation
module cid_exec_sink (
    input wire logic i_clk,
    input wire logic i_valid, // operation presented
    output int o_count        // operations consumed, kept across resets
);
    initial o_count = 0;
    // one operation taken per high cycle of the strobe
    always @(posedge i_clk) begin
        if (i_valid === 1'h1) o_count <= o_count + 1;
    end
endmodule : cid_exec_sink

// ===== verif/compact_instruction_decoder_tb.sv
`timescale 1ns/100ps
// drives halfwords at the falling edge and checks each result against a behavioural model
module compact_instruction_decoder_tb import cid_pkg::*;;
    logic i_clk;
    logic i_nrst;
    logic i_valid;
    logic [15:0] i_half;
    logic o_valid;
    cid_exp_s o_exp;
    int sink_count;
    int bad_count;
    int total_checks;
    int sent; // halfwords whose result must reach the sink
    logic [15:0] pend_q[$]; // halfwords whose result is due
    logic [15:0] seed;
    logic [15:0] rnd; // random halfword for the next step, kept off the live input until its edge
    // one or more halfwords per format, flag exceptions and undefined tails
    logic [15:0] dir_tab [0:32] = '{16'h0000, 16'h17FF, 16'h1800, 16'h1FFF, 16'h2000, 16'h3FFF, 16'h4000,
        16'h43FF, 16'h4400, 16'h4500, 16'h4600, 16'h4700, 16'h48FF, 16'h5000, 16'h5E00, 16'h6A51, 16'h7FFF,
        16'h8800, 16'h9FFF, 16'hA123, 16'hA900, 16'hB0FF, 16'hB07F, 16'hB5FF, 16'hBC00, 16'hB100, 16'hC9FF,
        16'hD0FE, 16'hDF01, 16'hE7FF, 16'hE800, 16'hF7FF, 16'hFFFF};

    cid_decoder i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid), .i_half(i_half), .o_valid(o_valid),
        .o_exp(o_exp));
    cid_exec_sink i_sink (.i_clk(i_clk), .i_valid(o_valid), .o_count(sink_count));

    initial begin
        i_clk = 1'h0;
        forever #50 i_clk = ~i_clk;
    end

    // format number of a halfword from its leading bits, 0 when nothing matches
    function automatic int ref_fmt(input logic [15:0] h);
        if (h[15:13] == 3'h0) return (h[12:11] == 2'h3) ? 2 : 1;
        if (h[15:13] == 3'h1) return 3;
        if (h[15:10] == 6'h10) return 4;
        if (h[15:10] == 6'h11) return 5;
        if (h[15:11] == 5'h09) return 6;
        if (h[15:12] == 4'h5) return h[9] ? 8 : 7;
        if (h[15:13] == 3'h3) return 9;
        if (h[15:12] == 4'h8) return 10;
        if (h[15:12] == 4'h9) return 11;
        if (h[15:12] == 4'hA) return 12;
        if (h[15:8] == 8'hB0) return 13;
        if (h[15:12] == 4'hB) return (h[10:9] == 2'h2) ? 14 : 0;
        if (h[15:12] == 4'hC) return 15;
        if (h[15:12] == 4'hD) return (h[11:8] == 4'hF) ? 17 : 16;
        if (h[15:11] == 5'h1C) return 18;
        return (h[15:12] == 4'hF) ? 19 : 0;
    endfunction : ref_fmt

    // expected immediate; the top bit says whether it is judged for this format
    function automatic logic [32:0] ref_imm(input logic [15:0] h, input int f);
        case (f)
            9: return {1'h1, h[12] ? {27'h0, h[10:6]} : {25'h0, h[10:6], 2'h0}};
            13: return {1'h1, h[7] ? 32'h0 - {23'h0, h[6:0], 2'h0} : {23'h0, h[6:0], 2'h0}};
            19: return {1'h1, h[11] ? {20'h0, h[10:0], 1'h0} : {{9{h[10]}}, h[10:0], 12'h0}};
            default: return 33'h0;
        endcase
    endfunction : ref_imm

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict;
        if (bad_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict

    // one falling edge: judge the result of the last rising edge, then offer the next input
    task automatic step(input logic v, input logic [15:0] h);
        logic [15:0] p;
        int f;
        logic [32:0] m;
        @(negedge i_clk);
        chk({31'h0, o_valid}, {31'h0, pend_q.size() != 0});
        if (pend_q.size() != 0) begin
            p = pend_q.pop_front();
            f = ref_fmt(p);
            m = ref_imm(p, f);
            chk({27'h0, o_exp.fmt}, 32'(f));
            chk({31'h0, o_exp.undef}, {31'h0, f == 0});
            chk({31'h0, o_exp.set_flags}, {31'h0, (f >= 1 && f <= 4) || (f == 5 && p[9:8] == 2'h1)});
            if (m[32]) chk(o_exp.imm, m[31:0]);
            if (f == 9) chk({22'h0, o_exp.load, o_exp.byte_sel, o_exp.rs, o_exp.rd},
                {22'h0, p[11], p[12], 1'h0, p[5:3], 1'h0, p[2:0]});
            if (f == 19) chk({30'h0, o_exp.hpart, o_exp.branch_link_op}, {30'h0, p[11], 1'h1});
            // operation kind flags: each belongs to exactly one format, all others must stay clear
            chk({27'h0, o_exp.branch_exchange_op, o_exp.branch_link_op, o_exp.software_trap_op,
                o_exp.load_multiple_op, o_exp.store_multiple_op}, {27'h0, f == 5 && p[9:8] == 2'h3, f == 19,
                f == 17, f == 15 && p[11], f == 15 && !p[11]});
        end
        i_valid = v;
        i_half = h;
        if (v) pend_q.push_back(h);
        if (v) sent++;
    endtask : step

    // reset, directed table, random traffic with gaps, then a reset while a result stands
    initial begin
        i_nrst = 1'h0;
        i_valid = 1'h0;
        i_half = 16'h0000;
        bad_count = 0;
        total_checks = 0;
        sent = 0;
        seed = 16'h0030;
        repeat (5) @(negedge i_clk);
        i_nrst = 1'h1;
        repeat (3) step(1'h0, 16'h0000);
        foreach (dir_tab[k]) step(1'h1, dir_tab[k]);
        for (int n = 0; n < 400; n++) begin
            seed = lfsr(seed);
            rnd = seed;
            seed = lfsr(seed);
            step(seed[1:0] != 2'h0, rnd);
        end
        // a valid halfword whose result is cut by the reset below
        step(1'h1, 16'hB07F);
        @(negedge i_clk);
        i_nrst = 1'h0; // result of the last halfword is standing now
        #1;
        chk({31'h0, o_valid}, 32'h0);
        sent -= pend_q.size();
        pend_q.delete();
        i_valid = 1'h0;
        repeat (2) @(negedge i_clk);
        i_nrst = 1'h1;
        repeat (3) step(1'h0, 16'h0000);
        step(1'h1, 16'hB0FF);
        step(1'h1, 16'hF7FF);
        repeat (2) step(1'h0, 16'h0000);
        chk(32'(sink_count), 32'(sent));
        give_verdict();
    end

    // cuts a hang short
    initial begin
        #5000000;
        bad_count++;
        give_verdict();
    end
endmodule : compact_instruction_decoder_tb
